// file: tb/battery_monitor_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the control and status registers
module battery_monitor_control_regs_tb;
  logic        mclk, rst_n, cmd_valid;
  logic [7:0]  cmd_byte, cmd_wdata, rd_data, rv;
  logic        brownout_pin, below_thr_pin, link_line_pin, gpio_in;
  logic        charge_active, discharge_active, fast_tick, slow_tick;
  logic        selfdis_tick, charge_tick, discharge_tick;
  logic [10:0] temperature;
  logic        gpio_out, gpio_oe, sleep, gpio_level;
  logic [2:0]  sleep_threshold_sel;
  int          error_cnt, n_checks;
  // 250 MHz clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  // Device under test
  bmc_regs i_dut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .brownout_pin(brownout_pin), .below_thr_pin(below_thr_pin),
    .link_line_pin(link_line_pin), .gpio_in(gpio_in),
    .charge_active(charge_active), .discharge_active(discharge_active),
    .fast_tick(fast_tick), .slow_tick(slow_tick), .selfdis_tick(selfdis_tick),
    .charge_tick(charge_tick), .discharge_tick(discharge_tick),
    .temperature(temperature), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .sleep(sleep), .sleep_threshold_sel(sleep_threshold_sel),
    .gpio_level(gpio_level));
  // Host partner
  bmc_host_model i_host (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data(rd_data));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read and compare
  task automatic rc(input string nm, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(nm, e, d);
  endtask
  // Let n edges pass, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Issue a flash command and poll, bounded, until it clears
  task automatic flash_command(input logic [7:0] c);
    int k;
    logic [7:0] d;
    i_host.wr(7'h62, c);
    d = 8'hff;
    k = 0;
    while (d !== 8'h00 && k < 100) begin
      i_host.rd(7'h62, d);
      k++;
    end
    chk("flash_command", 8'h00, d);
  endtask
  // Program one flash byte
  task automatic prog(input logic [6:0] a, input logic [7:0] d);
    i_host.wr(7'h6f, d);
    i_host.wr(7'h70, {1'b0, a});
    flash_command(bmc_pkg::FC_PROG);
  endtask
  // Reset values and an unmapped read
  task automatic t_reset;
    rc("mode_control", 7'h64, 8'h4f);
    chk("threshold", 8'h07, {5'h0, sleep_threshold_sel});
    chk("gpio_oe", 8'h00, {7'h0, gpio_oe});
    rc("counter_clear", 7'h63, 8'h00);
    rc("unmapped", 7'h7f, 8'h00);
  endtask
  // Pin direction and open-drain level
  task automatic t_gpio;
    i_host.wr(7'h64, 8'h0e);
    cyc(2);
    chk("gpio_oe low", 8'h01, {7'h0, gpio_oe});
    chk("gpio_out", 8'h00, {7'h0, gpio_out});
    i_host.wr(7'h64, 8'h4e);
    cyc(2);
    chk("gpio_oe off", 8'h00, {7'h0, gpio_oe});
    i_host.wr(7'h64, 8'h8e);
    cyc(2);
    chk("gpio_oe input", 8'h00, {7'h0, gpio_oe});
    gpio_in = 1'b1;
    cyc(4);
    chk("gpio_level", 8'h01, {7'h0, gpio_level});
  endtask
  // Temperature pair, read-only
  task automatic t_temp;
    temperature = 11'h5a3;
    cyc(3);
    i_host.wr(7'h60, 8'h00);
    rc("temperature_low", 7'h60, 8'ha3);
    rc("temperature_high", 7'h61, 8'h05);
    temperature = 11'h7ff;
    cyc(3);
    rc("temperature_high max", 7'h61, 8'h07);
  endtask
  // Flag set by host, by brownout, and host clear
  task automatic t_por;
    i_host.wr(7'h64, 8'hce);
    rc("mode por clear", 7'h64, 8'hce);
    i_host.wr(7'h64, 8'hcf);
    rc("mode por host", 7'h64, 8'hcf);
    chk("por no effect", 8'h00, {6'h0, gpio_oe, sleep});
    i_host.wr(7'h64, 8'hce);
    brownout_pin = 1'b1;
    cyc(4);
    brownout_pin = 1'b0;
    cyc(3);
    rc("mode brownout", 7'h64, 8'hcf);
  endtask
  // Each clear bit zeros its own pair only, then self-clears
  task automatic t_counters;
    i_host.wr(7'h63, 8'h1f);
    // Let the pending clear act before the first tick
    cyc(1);
    {charge_active, discharge_active} = 2'b11;
    repeat (3) begin
      {fast_tick, selfdis_tick, charge_tick, discharge_tick} = 4'hf;
      cyc(1);
      {fast_tick, selfdis_tick, charge_tick, discharge_tick} = 4'h0;
      cyc(1);
    end
    {charge_active, discharge_active} = 2'b00;
    for (int i = 0; i < 5; i++) begin
      i_host.wr(7'h63, 8'h01 << (4 - i));
      rc("counter low", 7'h65 + 7'(2 * i), 8'h00);
      rc("counter high", 7'h66 + 7'(2 * i), 8'h00);
      if (i < 4) rc("other kept", 7'h67 + 7'(2 * i), 8'h03);
      rc("clear self", 7'h63, 8'h00);
    end
  endtask
  // Charge-time counter passes its top, then runs slow
  task automatic t_rollover;
    charge_active = 1'b1;
    fast_tick = 1'b1;
    cyc(65536);
    fast_tick = 1'b0;
    i_host.rd(7'h64, rv);
    chk("charge_time_rollover", 8'h01, {7'h0, rv[5]});
    chk("discharge_time_rollover", 8'h00, {7'h0, rv[4]});
    rc("charge time wrapped", 7'h66, 8'h00);
    fast_tick = 1'b1;
    cyc(1);
    {fast_tick, slow_tick} = 2'b01;
    cyc(1);
    slow_tick = 1'b0;
    rc("slow rate", 7'h65, 8'h01);
    charge_active = 1'b0;
    i_host.wr(7'h63, 8'h10);
    i_host.rd(7'h64, rv);
    chk("rollover cleared", 8'h00, {7'h0, rv[5]});
    rc("charge time zero", 7'h65, 8'h00);
  endtask
  // Byte program, page erases, RAM transfers, unknown code
  task automatic t_flash;
    flash_command(bmc_pkg::FC_ERASE0);
    rc("erased end", 7'h1f, 8'hff);
    prog(7'h05, 8'h3c);
    rc("programmed", 7'h05, 8'h3c);
    prog(7'h05, 8'hf0);
    rc("and result", 7'h05, 8'h30);
    flash_command(bmc_pkg::FC_ERASE2);
    prog(7'h45, 8'h12);
    rc("page2 byte", 7'h45, 8'h12);
    flash_command(bmc_pkg::FC_ERASE2);
    rc("page2 erased", 7'h45, 8'hff);
    flash_command(bmc_pkg::FC_ERASE1);
    rc("page0 kept", 7'h05, 8'h30);
    flash_command(bmc_pkg::FC_ERASE0);
    i_host.wr(7'h25, 8'ha5);
    i_host.wr(7'h3f, 8'h00);
    flash_command(bmc_pkg::FC_RAM2FL);
    rc("ram to flash", 7'h05, 8'ha5);
    rc("ram to flash end", 7'h1f, 8'h00);
    i_host.wr(7'h25, 8'h00);
    flash_command(bmc_pkg::FC_FL2RAM);
    rc("flash to ram", 7'h25, 8'ha5);
    flash_command(8'h33);
    rc("unknown no action", 7'h05, 8'ha5);
    chk("unknown no sleep", 8'h00, {7'h0, sleep});
  endtask
  // Power-down gated by threshold, woken by either link edge
  task automatic t_sleep;
    i_host.wr(7'h64, 8'hce);
    flash_command(bmc_pkg::FC_PWRDN);
    cyc(4);
    chk("awake above", 8'h00, {7'h0, sleep});
    below_thr_pin = 1'b1;
    cyc(3);
    flash_command(bmc_pkg::FC_PWRDN);
    cyc(10);
    chk("asleep below", 8'h01, {7'h0, sleep});
    link_line_pin = 1'b1;
    cyc(5);
    chk("rising wake", 8'h00, {7'h0, sleep});
    below_thr_pin = 1'b0;
    i_host.wr(7'h64, 8'hc0);
    cyc(2);
    chk("threshold zero", 8'h00, {5'h0, sleep_threshold_sel});
    flash_command(bmc_pkg::FC_PWRDN);
    chk("sleep at once", 8'h01, {7'h0, sleep});
    link_line_pin = 1'b0;
    cyc(5);
    chk("falling wake", 8'h00, {7'h0, sleep});
  endtask
  // Counts, verdict, end of run
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #380000;
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {brownout_pin, below_thr_pin, link_line_pin, gpio_in} = 4'h0;
    {charge_active, discharge_active, fast_tick, slow_tick} = 4'h0;
    {selfdis_tick, charge_tick, discharge_tick} = 3'h0;
    temperature = 11'h000;
    cyc(10);
    rst_n = 1'b1;
    t_reset();
    t_gpio();
    t_temp();
    t_por();
    t_counters();
    t_rollover();
    t_flash();
    t_sleep();
    summarize();
  end
endmodule
`default_nettype wire

// file: tb/bmc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host on the register link: one command at a time, payload scrambled when idle
module bmc_host_model (
  // Clock
  input  wire logic       mclk,
  // Command strobe and payload
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte,
  output logic [7:0]      cmd_wdata,
  // Read answer
  input  wire logic [7:0] rd_data
);
  // Quiet link at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
    cmd_wdata = 8'h00;
  end
  // One strobe, taken at the next edge, then released
  task automatic send(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_byte  = {w, a};
    // Spare clear bits always go out as zeros
    cmd_wdata = (w && a == bmc_pkg::ADDR_CNT_CLR) ? (d & bmc_pkg::CLR_USED_MASK) : d;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    // Stale payload must not look valid
    cmd_byte  = ~cmd_byte;
    cmd_wdata = ~cmd_wdata;
  endtask
  // Register write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send(1'b1, a, d);
  endtask
  // Register read, answer taken one edge after the command
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    send(1'b0, a, 8'h00);
    @(posedge mclk);
    #1;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// file: verilog/bmc_pkg.sv
package bmc_pkg;
  // Register addresses on the serial link
  localparam logic [6:0] ADDR_TEMP_LOW  = 7'h60;
  localparam logic [6:0] ADDR_TEMP_HIGH = 7'h61;
  localparam logic [6:0] ADDR_FLASH_CMD = 7'h62;
  localparam logic [6:0] ADDR_CNT_CLR   = 7'h63;
  localparam logic [6:0] ADDR_MODE      = 7'h64;
  localparam logic [6:0] ADDR_CHG_TIME_L = 7'h65;
  localparam logic [6:0] ADDR_CHG_TIME_H = 7'h66;
  localparam logic [6:0] ADDR_DIS_TIME_L = 7'h67;
  localparam logic [6:0] ADDR_DIS_TIME_H = 7'h68;
  localparam logic [6:0] ADDR_SELFDIS_L  = 7'h69;
  localparam logic [6:0] ADDR_SELFDIS_H  = 7'h6a;
  localparam logic [6:0] ADDR_CHG_CNT_L  = 7'h6b;
  localparam logic [6:0] ADDR_CHG_CNT_H  = 7'h6c;
  localparam logic [6:0] ADDR_DIS_CNT_L  = 7'h6d;
  localparam logic [6:0] ADDR_DIS_CNT_H  = 7'h6e;
  localparam logic [6:0] ADDR_PROG_DATA  = 7'h6f;
  localparam logic [6:0] ADDR_PROG_ADDR  = 7'h70;
  localparam logic [6:0] ADDR_RAM_BASE   = 7'h20;
  // Command byte layout
  localparam int CMD_WRITE_BIT = 7;
  // Mode register fields
  localparam int MODE_GPIO_DIR = 7;
  localparam int MODE_GPIO_LVL = 6;
  localparam int MODE_CT_ROLL  = 5;
  localparam int MODE_DT_ROLL  = 4;
  localparam int MODE_THR_HI   = 3;
  localparam int MODE_THR_LO   = 1;
  localparam int MODE_POR      = 0;
  localparam logic [7:0] MODE_RESET = 8'h4f;
  // Clear register fields
  localparam int CLR_CT  = 4;
  localparam int CLR_DT  = 3;
  localparam int CLR_SD  = 2;
  localparam int CLR_CC  = 1;
  localparam int CLR_DC  = 0;
  localparam logic [7:0] CLR_USED_MASK = 8'h1f;
  // Temperature high byte keeps three live bits
  localparam logic [7:0] TEMP_HIGH_MASK = 8'h07;
  // Flash command codes
  localparam logic [7:0] FC_NONE     = 8'h00;
  localparam logic [7:0] FC_PROG     = 8'h0f;
  localparam logic [7:0] FC_ERASE0   = 8'h40;
  localparam logic [7:0] FC_ERASE1   = 8'h41;
  localparam logic [7:0] FC_ERASE2   = 8'h42;
  localparam logic [7:0] FC_RAM2FL   = 8'h45;
  localparam logic [7:0] FC_FL2RAM   = 8'h48;
  localparam logic [7:0] FC_PWRDN    = 8'hf6;
  // Flash geometry, erased value and counter top value
  localparam int FLASH_DEPTH = 96;
  localparam int PAGE_SIZE   = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // Data byte reads back zero for unmapped addresses
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // Flash engine state
  typedef enum logic [2:0] {
    FE_IDLE, FE_PROG, FE_ERASE, FE_R2F, FE_F2R, FE_DONE
  } bmc_fe_state_t;
endpackage

// file: verilog/bmc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module bmc_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Decoded link transaction: command byte, write data, strobe
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic [7:0]  cmd_wdata,
  output logic [7:0]       rd_data,
  // Analog side inputs (asynchronous pins)
  input  wire logic        brownout_pin,
  input  wire logic        below_thr_pin,
  input  wire logic        link_line_pin,
  input  wire logic        gpio_in,
  // Counter enables, event ticks and temperature from the datapath on mclk
  input  wire logic        charge_active,
  input  wire logic        discharge_active,
  input  wire logic        fast_tick,
  input  wire logic        slow_tick,
  input  wire logic        selfdis_tick,
  input  wire logic        charge_tick,
  input  wire logic        discharge_tick,
  input  wire logic [10:0] temperature,
  // Outputs
  output logic             gpio_out,
  output logic             gpio_oe,
  output logic             sleep,
  output logic [2:0]       sleep_threshold_sel,
  output logic             gpio_level
);
  // Synchronised pins
  logic brownout_s, below_thr_s, link_s, gpio_s;
  bmc_sync u_s0 (.mclk(mclk), .rst_n(rst_n), .async_in(brownout_pin),  .sync_out(brownout_s));
  bmc_sync u_s1 (.mclk(mclk), .rst_n(rst_n), .async_in(below_thr_pin), .sync_out(below_thr_s));
  bmc_sync u_s2 (.mclk(mclk), .rst_n(rst_n), .async_in(link_line_pin), .sync_out(link_s));
  bmc_sync u_s3 (.mclk(mclk), .rst_n(rst_n), .async_in(gpio_in),       .sync_out(gpio_s));

  // Register state
  logic [7:0]  mode_q, mode_d;             // Mode register
  logic [7:0]  clr_q, clr_d;               // Counter clear register
  logic [7:0]  flash_command_q, flash_command_d;             // Flash command register
  logic [7:0]  pdata_q, pdata_d;           // Program data
  logic [7:0]  paddr_q, paddr_d;           // Program address
  logic [15:0] ct_q, ct_d, dt_q, dt_d;     // Time counters
  logic [15:0] sd_q, sd_d, cc_q, cc_d, dc_q, dc_d;
  logic [10:0] temp_q, temp_d;             // Temperature snapshot
  logic        link_prev_q, link_prev_d;   // Last link level
  logic        sleep_d;
  logic        gpio_out_d, gpio_oe_d, gpio_lvl_d;
  logic [7:0]  rd_d;
  // Flash engine
  bmc_pkg::bmc_fe_state_t fe_q, fe_d;
  logic [6:0]  fe_idx_q, fe_idx_d;         // Walk index
  logic [6:0]  fe_base_q, fe_base_d;       // Erase page base
  logic [7:0]  flash_q [bmc_pkg::FLASH_DEPTH];
  logic [7:0]  ram_q   [bmc_pkg::PAGE_SIZE];
  logic        fl_we, ram_we;
  logic [6:0]  fl_wa;
  logic [4:0]  ram_wa;
  logic [7:0]  fl_wd, ram_wd;

  // Decoded write and read strobes, RAM window select
  logic wr, rd_en, ram_sel;
  logic [6:0] addr;
  always_comb begin
    wr    = cmd_valid & cmd_byte[bmc_pkg::CMD_WRITE_BIT];
    rd_en = cmd_valid & ~cmd_byte[bmc_pkg::CMD_WRITE_BIT];
    addr  = cmd_byte[6:0];
    ram_sel = (addr >= bmc_pkg::ADDR_RAM_BASE) && (addr < 7'h40);  // Scratch RAM window
  end

  // Time counter step with rollover flag handling
  function automatic logic [16:0] time_step(input logic [15:0] c, input logic roll,
                                            input logic act, input logic ft, input logic st);
    logic [15:0] n;
    logic        r;
    n = c;
    r = roll;
    if (act && (roll ? st : ft)) begin
      n = c + 16'h0001;
      if (c == bmc_pkg::CNT_MAX) begin
        r = ~roll;
      end
    end
    return {r, n};
  endfunction

  // Mode, clear and counter next values
  always_comb begin
    logic [16:0] cts, dts;
    cts = time_step(ct_q, mode_q[bmc_pkg::MODE_CT_ROLL], charge_active, fast_tick, slow_tick);
    dts = time_step(dt_q, mode_q[bmc_pkg::MODE_DT_ROLL], discharge_active, fast_tick, slow_tick);
    mode_d  = mode_q;
    clr_d   = clr_q;
    pdata_d = pdata_q;
    paddr_d = paddr_q;
    ct_d = cts[15:0];
    dt_d = dts[15:0];
    sd_d = sd_q + {15'h0000, selfdis_tick};
    cc_d = cc_q + {15'h0000, charge_tick};
    dc_d = dc_q + {15'h0000, discharge_tick};
    mode_d[bmc_pkg::MODE_CT_ROLL] = cts[16];
    mode_d[bmc_pkg::MODE_DT_ROLL] = dts[16];
    if (wr) begin
      case (addr)
        bmc_pkg::ADDR_MODE:      mode_d = cmd_wdata;
        bmc_pkg::ADDR_CNT_CLR:   clr_d = cmd_wdata & bmc_pkg::CLR_USED_MASK;
        bmc_pkg::ADDR_PROG_DATA: pdata_d = cmd_wdata;
        bmc_pkg::ADDR_PROG_ADDR: paddr_d = cmd_wdata;
        default: ;
      endcase
    end
    // Brownout wins over host write
    if (brownout_s) begin
      mode_d[bmc_pkg::MODE_POR] = 1'b1;
    end
    // Pending clear bits act one cycle after write, then self-clear
    if (clr_q[bmc_pkg::CLR_CT]) begin
      ct_d = '0;
      mode_d[bmc_pkg::MODE_CT_ROLL] = 1'b0;
      clr_d[bmc_pkg::CLR_CT] = 1'b0;
    end
    if (clr_q[bmc_pkg::CLR_DT]) begin
      dt_d = '0;
      mode_d[bmc_pkg::MODE_DT_ROLL] = 1'b0;
      clr_d[bmc_pkg::CLR_DT] = 1'b0;
    end
    if (clr_q[bmc_pkg::CLR_SD]) begin
      sd_d = '0;
      clr_d[bmc_pkg::CLR_SD] = 1'b0;
    end
    if (clr_q[bmc_pkg::CLR_CC]) begin
      cc_d = '0;
      clr_d[bmc_pkg::CLR_CC] = 1'b0;
    end
    if (clr_q[bmc_pkg::CLR_DC]) begin
      dc_d = '0;
      clr_d[bmc_pkg::CLR_DC] = 1'b0;
    end
  end

  // Flash engine next state
  always_comb begin
    fe_d      = fe_q;
    fe_idx_d  = fe_idx_q;
    fe_base_d = fe_base_q;
    flash_command_d    = flash_command_q;
    fl_we = 1'b0; fl_wa = '0; fl_wd = '0;
    ram_we = 1'b0; ram_wa = '0; ram_wd = '0;
    sleep_d     = sleep;
    link_prev_d = link_s;
    case (fe_q)
      bmc_pkg::FE_IDLE: begin
        if (wr && ram_sel) begin                             // Host fills scratch RAM
          ram_we = 1'b1; ram_wa = addr[4:0]; ram_wd = cmd_wdata;
        end
        if (wr && addr == bmc_pkg::ADDR_FLASH_CMD) begin
          flash_command_d   = cmd_wdata;
          fe_idx_d = '0;
          case (cmd_wdata)
            bmc_pkg::FC_PROG:   fe_d = bmc_pkg::FE_PROG;
            bmc_pkg::FC_ERASE0: begin fe_d = bmc_pkg::FE_ERASE; fe_base_d = 7'h00; end
            bmc_pkg::FC_ERASE1: begin fe_d = bmc_pkg::FE_ERASE; fe_base_d = 7'h20; end
            bmc_pkg::FC_ERASE2: begin fe_d = bmc_pkg::FE_ERASE; fe_base_d = 7'h40; end
            bmc_pkg::FC_RAM2FL: fe_d = bmc_pkg::FE_R2F;
            bmc_pkg::FC_FL2RAM: fe_d = bmc_pkg::FE_F2R;
            bmc_pkg::FC_PWRDN: begin
              if (below_thr_s || mode_q[3:1] == 3'b000) begin
                sleep_d = 1'b1;
              end
              fe_d = bmc_pkg::FE_DONE;
            end
            default: fe_d = bmc_pkg::FE_DONE;
          endcase
        end
      end
      bmc_pkg::FE_PROG: begin
        fl_we = paddr_q < 8'(bmc_pkg::FLASH_DEPTH);
        fl_wa = paddr_q[6:0];
        fl_wd = pdata_q & flash_q[paddr_q[6:0]];
        fe_d  = bmc_pkg::FE_DONE;
      end
      bmc_pkg::FE_ERASE, bmc_pkg::FE_R2F, bmc_pkg::FE_F2R: begin
        if (fe_q == bmc_pkg::FE_ERASE) begin
          fl_we = 1'b1;
          fl_wa = fe_base_q + fe_idx_q;
          fl_wd = bmc_pkg::ERASED_BYTE;
        end else if (fe_q == bmc_pkg::FE_R2F) begin
          fl_we = 1'b1;
          fl_wa = fe_idx_q;
          fl_wd = ram_q[fe_idx_q[4:0]];
        end else begin
          ram_we = 1'b1;
          ram_wa = fe_idx_q[4:0];
          ram_wd = flash_q[fe_idx_q];
        end
        fe_idx_d = fe_idx_q + 7'h01;
        if (fe_idx_q == 7'(bmc_pkg::PAGE_SIZE - 1)) begin
          fe_d = bmc_pkg::FE_DONE;
        end
      end
      bmc_pkg::FE_DONE: begin
        flash_command_d = bmc_pkg::FC_NONE;
        fe_d   = bmc_pkg::FE_IDLE;
      end
      default: fe_d = bmc_pkg::FE_IDLE;
    endcase
    // Any edge on the link line wakes the device
    if (sleep && (link_s != link_prev_q)) begin
      sleep_d = 1'b0;
    end
  end

  // Read mux and pin outputs
  always_comb begin
    temp_d = temperature;
    case (addr)
      bmc_pkg::ADDR_TEMP_LOW:   rd_d = temp_q[7:0];
      bmc_pkg::ADDR_TEMP_HIGH:  rd_d = {5'h00, temp_q[10:8]};
      bmc_pkg::ADDR_FLASH_CMD:  rd_d = flash_command_q;
      bmc_pkg::ADDR_CNT_CLR:    rd_d = clr_q;
      bmc_pkg::ADDR_MODE:       rd_d = mode_q;
      bmc_pkg::ADDR_CHG_TIME_L: rd_d = ct_q[7:0];
      bmc_pkg::ADDR_CHG_TIME_H: rd_d = ct_q[15:8];
      bmc_pkg::ADDR_DIS_TIME_L: rd_d = dt_q[7:0];
      bmc_pkg::ADDR_DIS_TIME_H: rd_d = dt_q[15:8];
      bmc_pkg::ADDR_SELFDIS_L:  rd_d = sd_q[7:0];
      bmc_pkg::ADDR_SELFDIS_H:  rd_d = sd_q[15:8];
      bmc_pkg::ADDR_CHG_CNT_L:  rd_d = cc_q[7:0];
      bmc_pkg::ADDR_CHG_CNT_H:  rd_d = cc_q[15:8];
      bmc_pkg::ADDR_DIS_CNT_L:  rd_d = dc_q[7:0];
      bmc_pkg::ADDR_DIS_CNT_H:  rd_d = dc_q[15:8];
      bmc_pkg::ADDR_PROG_DATA:  rd_d = pdata_q;
      bmc_pkg::ADDR_PROG_ADDR:  rd_d = paddr_q;
      default: begin
        if (addr < 7'(bmc_pkg::FLASH_DEPTH)) begin
          rd_d = ram_sel ? ram_q[addr[4:0]] : flash_q[addr];
        end else begin
          rd_d = bmc_pkg::UNMAPPED_DATA;
        end
      end
    endcase
    if (!rd_en) begin
      rd_d = rd_data;
    end
    gpio_oe_d  = ~mode_q[bmc_pkg::MODE_GPIO_DIR] & ~mode_q[bmc_pkg::MODE_GPIO_LVL];
    gpio_out_d = 1'b0;
    gpio_lvl_d = gpio_s;
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= bmc_pkg::MODE_RESET;
      clr_q  <= '0;
      flash_command_q <= bmc_pkg::FC_NONE;
      pdata_q <= '0; paddr_q <= '0;
      ct_q <= '0; dt_q <= '0; sd_q <= '0; cc_q <= '0; dc_q <= '0;
      temp_q <= '0;
      link_prev_q <= 1'b0;
      sleep <= 1'b0;
      fe_q <= bmc_pkg::FE_IDLE; fe_idx_q <= '0; fe_base_q <= '0;
      rd_data <= '0; gpio_out <= 1'b0; gpio_oe <= 1'b0;
      gpio_level <= 1'b0; sleep_threshold_sel <= 3'h7;
    end else begin
      mode_q <= mode_d; clr_q <= clr_d; flash_command_q <= flash_command_d;
      pdata_q <= pdata_d; paddr_q <= paddr_d;
      ct_q <= ct_d; dt_q <= dt_d; sd_q <= sd_d; cc_q <= cc_d; dc_q <= dc_d;
      temp_q <= temp_d; link_prev_q <= link_prev_d; sleep <= sleep_d;
      fe_q <= fe_d; fe_idx_q <= fe_idx_d; fe_base_q <= fe_base_d;
      rd_data <= rd_d; gpio_out <= gpio_out_d; gpio_oe <= gpio_oe_d;
      gpio_level <= gpio_lvl_d;
      sleep_threshold_sel <= mode_q[bmc_pkg::MODE_THR_HI:bmc_pkg::MODE_THR_LO];
    end
  end

  // Memory arrays (no reset: nonvolatile and scratch contents)
  always_ff @(posedge mclk) begin
    if (fl_we) begin
      flash_q[fl_wa] <= fl_wd;
    end
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
  end

  // Checks
  chk_clr_self: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_q[bmc_pkg::CLR_CT] |=> (ct_q == '0 && !clr_q[bmc_pkg::CLR_CT]
      && !mode_q[bmc_pkg::MODE_CT_ROLL])) else $error("charge time clear failed");
  chk_clr_dt: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_q[bmc_pkg::CLR_DT] |=> (dt_q == '0 && !mode_q[bmc_pkg::MODE_DT_ROLL]))
    else $error("discharge time clear failed");
  chk_clr_cnt: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_q[bmc_pkg::CLR_CC] |=> cc_q == '0) else $error("charge count clear failed");
  chk_flash_command_done: assert property (@(posedge mclk) disable iff (!rst_n)
    fe_q == bmc_pkg::FE_DONE |=> flash_command_q == bmc_pkg::FC_NONE) else $error("command not cleared");
  chk_erase_len: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(fe_q == bmc_pkg::FE_ERASE) |-> ##32 fe_q == bmc_pkg::FE_DONE)
    else $error("erase length wrong");
  chk_gpio_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_q[bmc_pkg::MODE_GPIO_DIR] |=> !gpio_oe) else $error("input pin driven");
  chk_wake_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    (sleep && link_s != link_prev_q) |=> !sleep) else $error("no wake on edge");
  chk_temp_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_en && addr == bmc_pkg::ADDR_TEMP_HIGH) |=> rd_data[7:3] == 5'h00)
    else $error("temperature high reserved bits set");
  chk_clr_rsvd: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_q[7:5] == 3'h0 ##1 clr_q[7:5] == 3'h0) else $error("reserved clear bits set");
endmodule
`default_nettype wire

// file: verilog/bmc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two flip-flop synchroniser for one pin level
module bmc_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;   // First stage, read only by second
  logic meta_d;
  logic sync_d;

  // Next values
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule
`default_nettype wire
